/* File: src/pag_pkg.sv */
// Package for the port A GPIO block: register map, fields, reset values.
// Assumes a 32-bit AXI4-Lite master; every register is one aligned word.
package pag_pkg;
  localparam logic [4:0] PIN_VALUES_ADDR   = 5'h00;
  localparam logic [4:0] OUTPUT_LATCH_ADDR = 5'h04;
  localparam logic [4:0] DIRECTION_ADDR    = 5'h08;
  localparam logic [4:0] ANALOG_SEL_ADDR   = 5'h0c;
  localparam logic [4:0] PULLUP_CTRL_ADDR  = 5'h10;
  localparam logic [4:0] OPTION_ADDR       = 5'h14;
  localparam logic [4:0] ALT_PIN_SEL1_ADDR = 5'h18;
  localparam int         INPUT_ONLY_BIT    = 5;
  localparam int         PULLUP_BIT        = 5;
  localparam int         TX_SEL_BIT        = 0;
  localparam int         GLOBAL_PU_DIS_BIT = 7;
  localparam logic [7:0] DIRECTION_RST     = 8'hff;
  localparam logic [7:0] ANALOG_SEL_RST    = 8'h1f;
  localparam logic [7:0] PULLUP_CTRL_RST   = 8'h20;
  localparam logic [7:0] LATCH_RST         = 8'h00;
  localparam logic [7:0] ALT_PIN_SEL1_RST  = 8'h00;
  localparam logic       GLOBAL_PU_DIS_RST = 1'b1;
  localparam logic [1:0] RESP_OKAY         = 2'h0;
  localparam logic [1:0] RESP_SLVERR       = 2'h2;
endpackage

/* File: src/pag_sync.sv */
// Two-flop synchroniser for a bus of pin levels.
// Assumes the inputs are asynchronous to core_clk_i.
module pag_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             core_clk_i,
  input  wire logic             reset_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] stage1;

  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      stage1 <= '0;
      sync_o <= '0;
    end
    else
    begin
      stage1 <= async_i;
      sync_o <= stage1;
    end
  end
endmodule

/* File: src/pag_port_a.sv */
// Port A GPIO with serial transmit/clock pin steering, AXI4-Lite slave.
// Assumes pad levels arrive asynchronously; the pad adds the pull-up.
//
// Design decisions made here: the register addresses and register access over AXI4-Lite.
module pag_port_a #(
  parameter int WIDTH = 8
) (
  input  wire logic             core_clk_i,
  input  wire logic             reset_i,
  input  wire logic [4:0]       s_axi_awaddr,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  output logic [1:0]            s_axi_bresp,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  input  wire logic [4:0]       s_axi_araddr,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready,
  input  wire logic [WIDTH-1:0] port_a_pad_i,
  output logic      [WIDTH-1:0] port_a_pad_o,
  output logic      [WIDTH-1:0] port_a_pad_oe_o,
  output logic                  pin5_pullup_en_o,
  output logic      [WIDTH-1:0] analog_path_en_o,
  input  wire logic             master_clear_enable_fuse_i,
  input  wire logic             serial_tx_clock_function_i,
  input  wire logic             serial_tx_clock_oe_i,
  input  wire logic             port_b_pin2_dir_i,
  input  wire logic             port_b_pin5_dir_i,
  output logic                  port_b_pin2_o,
  output logic                  port_b_pin2_oe_o,
  output logic                  port_b_pin5_o,
  output logic                  port_b_pin5_oe_o
);
  logic [WIDTH-1:0] pins_sync;
  logic [WIDTH-1:0] port_a_output_latch;
  logic [WIDTH-1:0] port_a_direction;
  logic [WIDTH-1:0] port_a_analog_select;
  logic [WIDTH-1:0] port_a_pullup_control;
  logic             global_pullup_disable;
  logic             serial_tx_pin_select;
  logic             fuse_sync1, fuse_sync;
  logic [WIDTH-1:0] next_latch, next_direction;
  logic [WIDTH-1:0] next_analog, next_pullup;
  logic             next_global_pu, next_tx_sel;
  logic             aw_held, w_held, w_byte0;
  logic [4:0]       aw_addr, next_aw_addr;
  logic [31:0]      w_data, next_w_data, next_rdata;
  logic             next_aw_held, next_w_held, next_w_byte0;
  logic             next_bvalid, next_rvalid;
  logic [1:0]       next_bresp, next_rresp;
  logic [WIDTH-1:0] port_a_pin_values;
  logic [WIDTH-1:0] next_pad_o, next_pad_oe;
  logic             next_pu5, do_write, known;

  pag_sync #(.WIDTH(WIDTH)) u_pin_sync (
    .core_clk_i (core_clk_i),
    .reset_i    (reset_i),
    .async_i    (port_a_pad_i),
    .sync_o     (pins_sync)
  );

  // Digital reads of analog pins are forced low
  assign port_a_pin_values = pins_sync & ~port_a_analog_select;

  always_comb
  begin
    next_aw_held = aw_held;
    next_w_held  = w_held;
    next_aw_addr = aw_addr;
    next_w_data  = w_data;
    next_w_byte0 = w_byte0;
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_w_held  = 1'b1;
      next_w_data  = s_axi_wdata;
      next_w_byte0 = s_axi_wstrb[0];
    end
    do_write = aw_held && w_held && !s_axi_bvalid;
    if (do_write)
    begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
    end
  end

  always_comb
  begin
    next_latch     = port_a_output_latch;
    next_direction = port_a_direction;
    next_analog    = port_a_analog_select;
    next_pullup    = port_a_pullup_control;
    next_global_pu = global_pullup_disable;
    next_tx_sel    = serial_tx_pin_select;
    next_bvalid    = s_axi_bvalid && !s_axi_bready;
    next_bresp     = s_axi_bresp;
    known          = 1'b1;
    if (do_write)
    begin
      next_bvalid = 1'b1;
      case (aw_addr)
        pag_pkg::PIN_VALUES_ADDR, pag_pkg::OUTPUT_LATCH_ADDR:
          // Unwritten lanes keep sampled pin levels, not the latch
          next_latch = w_byte0 ? w_data[WIDTH-1:0] : port_a_pin_values;
        pag_pkg::DIRECTION_ADDR:
          if (w_byte0)
            next_direction = w_data[WIDTH-1:0];
        pag_pkg::ANALOG_SEL_ADDR:
          if (w_byte0)
            next_analog = w_data[WIDTH-1:0];
        pag_pkg::PULLUP_CTRL_ADDR:
          if (w_byte0)
            next_pullup[pag_pkg::PULLUP_BIT] = w_data[pag_pkg::PULLUP_BIT];
        pag_pkg::OPTION_ADDR:
          if (w_byte0)
            next_global_pu = w_data[pag_pkg::GLOBAL_PU_DIS_BIT];
        pag_pkg::ALT_PIN_SEL1_ADDR:
          if (w_byte0)
            next_tx_sel = w_data[pag_pkg::TX_SEL_BIT];
        default:
          known = 1'b0;
      endcase
      next_bresp = known ? pag_pkg::RESP_OKAY : pag_pkg::RESP_SLVERR;
    end
    next_direction[pag_pkg::INPUT_ONLY_BIT] = 1'b1;
  end

  always_comb
  begin
    next_rvalid = s_axi_rvalid && !s_axi_rready;
    next_rdata  = s_axi_rdata;
    next_rresp  = s_axi_rresp;
    if (s_axi_arvalid && s_axi_arready)
    begin
      next_rvalid = 1'b1;
      next_rdata  = 32'h0000_0000;
      next_rresp  = pag_pkg::RESP_OKAY;
      case (s_axi_araddr)
        pag_pkg::PIN_VALUES_ADDR:
          next_rdata[WIDTH-1:0] = port_a_pin_values;
        pag_pkg::OUTPUT_LATCH_ADDR:
          next_rdata[WIDTH-1:0] = port_a_output_latch;
        pag_pkg::DIRECTION_ADDR:
          next_rdata[WIDTH-1:0] = port_a_direction;
        pag_pkg::ANALOG_SEL_ADDR:
          next_rdata[WIDTH-1:0] = port_a_analog_select;
        pag_pkg::PULLUP_CTRL_ADDR:
          next_rdata[WIDTH-1:0] = port_a_pullup_control;
        pag_pkg::OPTION_ADDR:
          next_rdata[pag_pkg::GLOBAL_PU_DIS_BIT] = global_pullup_disable;
        pag_pkg::ALT_PIN_SEL1_ADDR:
          // Upper bits stay zero from the clear above
          next_rdata[pag_pkg::TX_SEL_BIT] = serial_tx_pin_select;
        default:
          next_rresp = pag_pkg::RESP_SLVERR;
      endcase
    end
  end

  always_comb
  begin
    // Drivers follow direction only; analog select plays no part
    next_pad_oe = ~port_a_direction;
    next_pad_oe[pag_pkg::INPUT_ONLY_BIT] = 1'b0;
    next_pad_o  = port_a_output_latch & next_pad_oe;
    next_pu5    = fuse_sync ||
                  (!global_pullup_disable &&
                   port_a_pullup_control[pag_pkg::PULLUP_BIT]);
    next_pu5    = next_pu5 && port_a_direction[pag_pkg::PULLUP_BIT];
  end

  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      port_a_output_latch   <= pag_pkg::LATCH_RST;
      port_a_direction      <= pag_pkg::DIRECTION_RST;
      port_a_analog_select  <= pag_pkg::ANALOG_SEL_RST;
      port_a_pullup_control <= pag_pkg::PULLUP_CTRL_RST;
      global_pullup_disable <= pag_pkg::GLOBAL_PU_DIS_RST;
      serial_tx_pin_select  <= pag_pkg::ALT_PIN_SEL1_RST[pag_pkg::TX_SEL_BIT];
      aw_held               <= 1'b0;
      w_held                <= 1'b0;
      aw_addr               <= 5'h00;
      w_data                <= 32'h0000_0000;
      w_byte0               <= 1'b0;
      s_axi_bvalid          <= 1'b0;
      s_axi_bresp           <= pag_pkg::RESP_OKAY;
      s_axi_rvalid          <= 1'b0;
      s_axi_rdata           <= 32'h0000_0000;
      s_axi_rresp           <= pag_pkg::RESP_OKAY;
      s_axi_awready         <= 1'b0;
      s_axi_wready          <= 1'b0;
      s_axi_arready         <= 1'b0;
      port_a_pad_o          <= '0;
      port_a_pad_oe_o       <= '0;
      pin5_pullup_en_o      <= 1'b0;
      analog_path_en_o      <= '0;
      fuse_sync1            <= 1'b0;
      fuse_sync             <= 1'b0;
      port_b_pin2_o         <= 1'b0;
      port_b_pin2_oe_o      <= 1'b0;
      port_b_pin5_o         <= 1'b0;
      port_b_pin5_oe_o      <= 1'b0;
    end
    else
    begin
      port_a_output_latch   <= next_latch;
      port_a_direction      <= next_direction;
      port_a_analog_select  <= next_analog;
      port_a_pullup_control <= next_pullup;
      global_pullup_disable <= next_global_pu;
      serial_tx_pin_select  <= next_tx_sel;
      aw_held               <= next_aw_held;
      w_held                <= next_w_held;
      aw_addr               <= next_aw_addr;
      w_data                <= next_w_data;
      w_byte0               <= next_w_byte0;
      s_axi_bvalid          <= next_bvalid;
      s_axi_bresp           <= next_bresp;
      s_axi_rvalid          <= next_rvalid;
      s_axi_rdata           <= next_rdata;
      s_axi_rresp           <= next_rresp;
      s_axi_awready         <= !next_aw_held && !s_axi_awready;
      s_axi_wready          <= !next_w_held && !s_axi_wready;
      s_axi_arready         <= !next_rvalid && !s_axi_arready;
      port_a_pad_o          <= next_pad_o;
      port_a_pad_oe_o       <= next_pad_oe;
      pin5_pullup_en_o      <= next_pu5;
      analog_path_en_o      <= port_a_analog_select;
      fuse_sync1            <= master_clear_enable_fuse_i;
      fuse_sync             <= fuse_sync1;
      // Unselected pin falls back to its own port B direction and drives low
      port_b_pin2_o         <= !serial_tx_pin_select &&
                               serial_tx_clock_function_i;
      port_b_pin2_oe_o      <= serial_tx_pin_select ? !port_b_pin2_dir_i
                               : serial_tx_clock_oe_i;
      port_b_pin5_o         <= serial_tx_pin_select &&
                               serial_tx_clock_function_i;
      port_b_pin5_oe_o      <= serial_tx_pin_select ? serial_tx_clock_oe_i
                               : !port_b_pin5_dir_i;
    end
  end

  property p_rsvd_zero;
    @(posedge core_clk_i) disable iff (reset_i)
      s_axi_rvalid && $past(s_axi_araddr) == pag_pkg::ALT_PIN_SEL1_ADDR &&
      $rose(s_axi_rvalid) |-> s_axi_rdata[31:1] == 31'h0;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero)
    else $error("select register upper bits not zero");

  property p_pin5_in;
    @(posedge core_clk_i) disable iff (reset_i)
      !port_a_pad_oe_o[pag_pkg::INPUT_ONLY_BIT] &&
      port_a_direction[pag_pkg::INPUT_ONLY_BIT];
  endproperty
  a_pin5_in: assert property (p_pin5_in)
    else $error("input-only pin driven");

  property p_oe_dir;
    @(posedge core_clk_i) disable iff (reset_i)
      ##1 port_a_pad_oe_o[0] == !$past(port_a_direction[0]);
  endproperty
  a_oe_dir: assert property (p_oe_dir)
    else $error("driver enable does not follow direction");

  property p_tx_route;
    @(posedge core_clk_i) disable iff (reset_i)
      serial_tx_pin_select && serial_tx_clock_function_i |=>
        port_b_pin5_o && !port_b_pin2_o;
  endproperty
  a_tx_route: assert property (p_tx_route)
    else $error("serial tx not on selected pin");
  property p_pu_out_off;
    @(posedge core_clk_i) disable iff (reset_i)
      pin5_pullup_en_o |-> !port_a_pad_oe_o[pag_pkg::PULLUP_BIT];
  endproperty
  a_pu_out_off: assert property (p_pu_out_off)
    else $error("pull-up on while output");
  property p_pu_global;
    @(posedge core_clk_i) disable iff (reset_i)
      global_pullup_disable && !fuse_sync |=> !pin5_pullup_en_o;
  endproperty
  a_pu_global: assert property (p_pu_global)
    else $error("pull-up on despite global disable");

  property p_mclr_pu;
    @(posedge core_clk_i) disable iff (reset_i)
      fuse_sync && port_a_direction[pag_pkg::PULLUP_BIT] |=> pin5_pullup_en_o;
  endproperty
  a_mclr_pu: assert property (p_mclr_pu)
    else $error("pull-up off with master clear enabled");

  property p_analog_zero;
    @(posedge core_clk_i) disable iff (reset_i)
      s_axi_arvalid && s_axi_arready &&
      s_axi_araddr == pag_pkg::PIN_VALUES_ADDR |=>
        (s_axi_rdata[WIDTH-1:0] & $past(port_a_analog_select)) == '0;
  endproperty
  a_analog_zero: assert property (p_analog_zero)
    else $error("analog pin read nonzero");
endmodule

/* File: verif/pag_pads.sv */
// Board-side pad model for port A: resolves each pin level.
// Assumes the bench supplies a board drive value and enable per pin.
module pag_pads (
  input  wire logic       core_clk_i,
  input  wire logic [7:0] pad_i,
  input  wire logic [7:0] oe_i,
  input  wire logic       pullup_i,
  input  wire logic [7:0] ext_i,
  input  wire logic [7:0] ext_en_i,
  output logic      [7:0] level_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] float_q = 8'h55;
  // Undriven pins other than a pulled-up pin 5 wander so a stale level never passes as a match
  always @(posedge core_clk_i)
  begin
    float_q <= ~float_q;
  end
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      if (oe_i[i])
        level_o[i] = pad_i[i];
      else if (ext_en_i[i])
        level_o[i] = ext_i[i];
      else if (i == 5 && pullup_i)
        level_o[i] = 1'b1;
      else
        level_o[i] = float_q[i];
    end
  end
endmodule

/* File: verif/pag_port_a_bench.sv */
// Self-checking bench for the port A block through its AXI4-Lite port.
// Assumes the pad model closes the loop from pad outputs to pad inputs.
module pag_port_a_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        core_clk_i = 1'b0;
  logic        reset_i = 1'b1;
  logic [4:0]  awaddr = 5'h00, araddr = 5'h00;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0]  wstrb = 4'h0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [7:0]  pad_o, pad_oe, level, analog_en, ext = 8'h00, ext_en = 8'h00;
  logic        pullup_en, fuse = 1'b0, tx = 1'b0, tx_oe = 1'b0;
  logic        b2_dir = 1'b1, b5_dir = 1'b1, b2_o, b2_oe, b5_o, b5_oe;
  int          fails = 0, n_compared = 0;

  pag_port_a dut (.core_clk_i(core_clk_i), .reset_i(reset_i),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .port_a_pad_i(level),
    .port_a_pad_o(pad_o), .port_a_pad_oe_o(pad_oe),
    .pin5_pullup_en_o(pullup_en), .analog_path_en_o(analog_en),
    .master_clear_enable_fuse_i(fuse), .serial_tx_clock_function_i(tx),
    .serial_tx_clock_oe_i(tx_oe), .port_b_pin2_dir_i(b2_dir),
    .port_b_pin5_dir_i(b5_dir), .port_b_pin2_o(b2_o),
    .port_b_pin2_oe_o(b2_oe), .port_b_pin5_o(b5_o),
    .port_b_pin5_oe_o(b5_oe));
  pag_pads pads (.core_clk_i(core_clk_i), .pad_i(pad_o), .oe_i(pad_oe),
    .pullup_i(pullup_en), .ext_i(ext), .ext_en_i(ext_en), .level_o(level));

  initial
  begin
    forever #20 core_clk_i = ~core_clk_i;
  end

  task automatic test_done;
    if (fails == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d,
                    input logic [3:0] s, output logic [1:0] r);
    bit aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge core_clk_i);
    awaddr <= a;
    wdata <= 32'(d);
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok))
    begin
      @(posedge core_clk_i);
      if (awready === 1'b1 && !aw_ok)
      begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready === 1'b1 && !w_ok)
      begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge core_clk_i); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge core_clk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge core_clk_i); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge core_clk_i); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic wset(input logic [4:0] a, input logic [7:0] d);
    logic [1:0] r;
    wr(a, d, 4'h1, r);
  endtask

  // Response and data of one read compared in one call
  task automatic rchk(input logic [4:0] a, input logic [7:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk(32'(r), 32'(pag_pkg::RESP_OKAY));
    chk(d, 32'(e));
  endtask

  task automatic t_reset;
    logic [31:0] d;
    logic [1:0]  r;
    rchk(pag_pkg::DIRECTION_ADDR, 8'hff);
    rchk(pag_pkg::ANALOG_SEL_ADDR, 8'h1f);
    rchk(pag_pkg::PULLUP_CTRL_ADDR, 8'h20);
    rchk(pag_pkg::OPTION_ADDR, 8'h80);
    rchk(pag_pkg::ALT_PIN_SEL1_ADDR, 8'h00);
    rchk(pag_pkg::OUTPUT_LATCH_ADDR, 8'h00);
    chk(32'({pad_oe, pullup_en}), 32'h0);
    rd(5'h1c, d, r);
    chk(32'(r), 32'(pag_pkg::RESP_SLVERR));
    wr(5'h1c, 8'hff, 4'h1, r);
    chk(32'(r), 32'(pag_pkg::RESP_SLVERR));
  endtask

  task automatic t_direction;
    wset(pag_pkg::ANALOG_SEL_ADDR, 8'h00);
    wset(pag_pkg::OUTPUT_LATCH_ADDR, 8'h85);
    wset(pag_pkg::DIRECTION_ADDR, 8'h0c);
    ext <= 8'h24;
    ext_en <= 8'h2c;
    rchk(pag_pkg::DIRECTION_ADDR, 8'h2c);
    rchk(pag_pkg::OUTPUT_LATCH_ADDR, 8'h85);
    chk(32'({pad_oe, pad_o}), 32'hd381);
    repeat (4) @(posedge core_clk_i);
    rchk(pag_pkg::PIN_VALUES_ADDR, 8'ha5);
  endtask

  task automatic t_analog;
    wset(pag_pkg::DIRECTION_ADDR, 8'hff);
    wset(pag_pkg::ANALOG_SEL_ADDR, 8'h0f);
    ext <= 8'h5a;
    ext_en <= 8'hff;
    repeat (4) @(posedge core_clk_i);
    rchk(pag_pkg::PIN_VALUES_ADDR, 8'h50);
    chk(32'(analog_en), 32'h0f);
    // Outputs on analog pins still drive but read back as zero
    wset(pag_pkg::ANALOG_SEL_ADDR, 8'h1f);
    wset(pag_pkg::DIRECTION_ADDR, 8'h00);
    repeat (4) @(posedge core_clk_i);
    chk(32'({pad_oe, pad_o}), 32'hdf85);
    rchk(pag_pkg::PIN_VALUES_ADDR, 8'h80);
  endtask

  task automatic t_port_write;
    logic [1:0] r;
    wset(pag_pkg::DIRECTION_ADDR, 8'hff);
    wset(pag_pkg::ANALOG_SEL_ADDR, 8'h00);
    ext <= 8'h96;
    wset(pag_pkg::PIN_VALUES_ADDR, 8'h1c);
    rchk(pag_pkg::OUTPUT_LATCH_ADDR, 8'h1c);
    rchk(pag_pkg::PIN_VALUES_ADDR, 8'h96);
    wr(pag_pkg::PIN_VALUES_ADDR, 8'h00, 4'h0, r);
    rchk(pag_pkg::OUTPUT_LATCH_ADDR, 8'h96);
    // Direction write with lane 0 off must leave the register alone
    wr(pag_pkg::DIRECTION_ADDR, 8'h00, 4'h0, r);
    chk(32'(r), 32'(pag_pkg::RESP_OKAY));
    rchk(pag_pkg::DIRECTION_ADDR, 8'hff);
  endtask

  task automatic t_pullup;
    wset(pag_pkg::OPTION_ADDR, 8'h00);
    wset(pag_pkg::PULLUP_CTRL_ADDR, 8'hff);
    rchk(pag_pkg::PULLUP_CTRL_ADDR, 8'h20);
    chk(32'(pullup_en), 32'h1);
    wset(pag_pkg::PULLUP_CTRL_ADDR, 8'h00);
    repeat (2) @(posedge core_clk_i);
    chk(32'(pullup_en), 32'h0);
    wset(pag_pkg::PULLUP_CTRL_ADDR, 8'h20);
    wset(pag_pkg::OPTION_ADDR, 8'h80);
    repeat (2) @(posedge core_clk_i);
    chk(32'(pullup_en), 32'h0);
    fuse <= 1'b1;
    repeat (5) @(posedge core_clk_i);
    chk(32'(pullup_en), 32'h1);
    fuse <= 1'b0;
  endtask

  task automatic t_tx_select;
    tx <= 1'b1;
    tx_oe <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    chk(32'({b2_o, b2_oe, b5_oe}), 32'h6);
    wset(pag_pkg::ALT_PIN_SEL1_ADDR, 8'hff);
    rchk(pag_pkg::ALT_PIN_SEL1_ADDR, 8'h01);
    chk(32'({b5_o, b5_oe, b2_oe}), 32'h6);
    tx <= 1'b0;
    b2_dir <= 1'b0;
    repeat (3) @(posedge core_clk_i);
    chk(32'({b5_o, b2_oe}), 32'h1);
    rchk(pag_pkg::DIRECTION_ADDR, 8'hff);
  endtask

  initial
  begin
    repeat (20) @(posedge core_clk_i);
    reset_i <= 1'b0;
    @(posedge core_clk_i);
    t_reset;
    t_direction;
    t_analog;
    t_port_write;
    t_pullup;
    t_tx_select;
    test_done;
  end

  // Whole run needs well under a tenth of this span
  initial
  begin
    #400000;
    fails++;
    test_done;
  end
endmodule
